// *** hw/ofpc_reg_byte.sv ***
// Purpose: one byte-wide configuration register with its own reset value
// Assumes: write enable is a one-cycle strobe on sys_clk
// Notes:   q_ff comes straight from a flip-flop
`timescale 1ns/1ps
module ofpc_reg_byte #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] q_ff
);
    // =================================================================
    // storage
    // plain store: reserved bits are kept as written, software owns them
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            q_ff <= RESET_VALUE;
        else if (wrEn)
            q_ff <= wrData;
    end
endmodule // ofpc_reg_byte

// *** hw/output_feedback_page_config.sv ***
// Purpose: register slice for output alignment, frequency select, feedback and page
// Assumes: one sys_clk at 20 MHz, asynchronous active-low reset, no wait states
// Notes:   outputs are registered copies of fields, pageSel_ff a registered one-hot page decode; the analog parts use them
`timescale 1ns/1ps
`include "ofpc_defs.svh"
module output_feedback_page_config (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic [`OFPC_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWrStb,
    input  wire logic                    regRdStb,
    output logic      [7:0]              regRdData_ff,
    output logic                         outAEnable_ff,
    output logic                         outBEnable_ff,
    output logic      [1:0]              outAAlignment_ff,
    output logic      [1:0]              outBAlignment_ff,
    output logic      [2:0]              outAFreqSel_ff,
    output logic      [2:0]              outBFreqSel_ff,
    output logic                         loopbackClockOutEn_ff,
    output logic                         sharedPinRole_ff,
    output logic signed [7:0]            finePhaseTrim_ff,
    output logic      [7:0]              extPage_ff,
    output logic      [4:0]              pageSel_ff
);
    // =================================================================
    // register storage
    localparam int NREG = 5;
    localparam logic [7:0] RSTV [NREG] = '{`OFPC_RST_OUT_CTRL, `OFPC_RST_FREQ_SEL,
        `OFPC_RST_FB_CTRL, `OFPC_RST_TRIM, `OFPC_RST_PAGE};
    localparam logic [`OFPC_ADDR_W-1:0] OFS [NREG] = '{`OFPC_OFS_OUT_CTRL,
        `OFPC_OFS_FREQ_SEL, `OFPC_OFS_FB_CTRL, `OFPC_OFS_TRIM, `OFPC_OFS_PAGE};

    logic [7:0] regQ [NREG];
    logic [NREG-1:0] hit;

    // one register per offset, each with its own decode
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_reg
            assign hit[gi] = (regAddr == OFS[gi]);
            ofpc_reg_byte #(.RESET_VALUE(RSTV[gi])) u_reg (
                .sys_clk (sys_clk),
                .reset_n (reset_n),
                .wrEn    (regWrStb & hit[gi]),
                .wrData  (regWrData),
                .q_ff    (regQ[gi])
            );
        end
    endgenerate

    // =================================================================
    // read path: data stand one cycle after the strobe, unmapped reads zero
    logic [7:0] nxt_rdData;
    always_comb
    begin
        nxt_rdData = `OFPC_RD_ZERO;
        for (int i = 0; i < NREG; i++)
            if (hit[i])
                nxt_rdData = regQ[i];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            regRdData_ff <= `OFPC_RD_ZERO;
        else if (regRdStb)
            regRdData_ff <= nxt_rdData;
        else
            regRdData_ff <= `OFPC_RD_ZERO; // holds only in the cycle after the read
    end

    // =================================================================
    // page decode; reserved pages are flagged, software must avoid them
    ofpc_pkg::ofpc_page_e nxt_page;
    always_comb
    begin
        case (regQ[4])
            `OFPC_PAGE_GENERAL: nxt_page = ofpc_pkg::OFPC_PG_GENERAL;
            `OFPC_PAGE_FREERUN: nxt_page = ofpc_pkg::OFPC_PG_FREERUN;
            `OFPC_PAGE_REF9:    nxt_page = ofpc_pkg::OFPC_PG_REF9;
            `OFPC_PAGE_REF9_CC: nxt_page = ofpc_pkg::OFPC_PG_REF9_CC;
            default:            nxt_page = ofpc_pkg::OFPC_PG_RESERVED;
        endcase
    end

    // =================================================================
    // field outputs, one flop stage behind the registers
    // each concern has its own flop group; reset images are cut from the
    // register reset values, except pageSel_ff, which loads OFPC_PG_GENERAL

    // output enables, a cleared bit leaves the pad in high impedance
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outAEnable_ff <= RSTV[0][`OFPC_EN_A_BIT];
            outBEnable_ff <= RSTV[0][`OFPC_EN_B_BIT];
        end
        else
        begin
            outAEnable_ff <= regQ[0][`OFPC_EN_A_BIT];
            outBEnable_ff <= regQ[0][`OFPC_EN_B_BIT];
        end
    end

    // output alignment codes, low codes advance, high codes delay
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outAAlignment_ff <= RSTV[0][`OFPC_ALIGN_A_HI:`OFPC_ALIGN_A_LO];
            outBAlignment_ff <= RSTV[0][`OFPC_ALIGN_B_HI:`OFPC_ALIGN_B_LO];
        end
        else
        begin
            outAAlignment_ff <= regQ[0][`OFPC_ALIGN_A_HI:`OFPC_ALIGN_A_LO];
            outBAlignment_ff <= regQ[0][`OFPC_ALIGN_B_HI:`OFPC_ALIGN_B_LO];
        end
    end

    // frequency select codes, passed on as stored
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outAFreqSel_ff <= RSTV[1][`OFPC_FSEL_A_HI:`OFPC_FSEL_A_LO];
            outBFreqSel_ff <= RSTV[1][`OFPC_FSEL_B_HI:`OFPC_FSEL_B_LO];
        end
        else
        begin
            outAFreqSel_ff <= regQ[1][`OFPC_FSEL_A_HI:`OFPC_FSEL_A_LO];
            outBFreqSel_ff <= regQ[1][`OFPC_FSEL_B_HI:`OFPC_FSEL_B_LO];
        end
    end

    // loopback clock enable, low parks the pin in high impedance
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            loopbackClockOutEn_ff <= RSTV[2][`OFPC_FB_EN_BIT];
        else
            loopbackClockOutEn_ff <= regQ[2][`OFPC_FB_EN_BIT];
    end

    // shared pin role; the pad logic must switch direction on this level
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            sharedPinRole_ff <= RSTV[2][`OFPC_PIN_ROLE_BIT];
        else
            sharedPinRole_ff <= regQ[2][`OFPC_PIN_ROLE_BIT];
    end

    // common fine trim for both output families, kept signed for its users
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            finePhaseTrim_ff <= RSTV[3];
        else
            finePhaseTrim_ff <= $signed(regQ[3]);
    end

    // extended page: raw value for the page mux, one-hot decode beside it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            extPage_ff <= RSTV[4];
            pageSel_ff <= ofpc_pkg::OFPC_PG_GENERAL;
        end
        else
        begin
            extPage_ff <= regQ[4];
            pageSel_ff <= nxt_page;
        end
    end

    // =================================================================
    // checks
    outa_enable_follows_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        outAEnable_ff == $past(regWrData[`OFPC_EN_A_BIT], 2))
        else $error("output a enable did not follow write");
    outb_align_tracks_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        outBAlignment_ff == $past(regWrData[`OFPC_ALIGN_B_HI:`OFPC_ALIGN_B_LO], 2))
        else $error("output b alignment wrong");
    outa_align_tracks_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        outAAlignment_ff == $past(regWrData[`OFPC_ALIGN_A_HI:`OFPC_ALIGN_A_LO], 2))
        else $error("output a alignment wrong");
    freq_sel_a_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_FREQ_SEL) |=> ##1
        outAFreqSel_ff == $past(regWrData[`OFPC_FSEL_A_HI:`OFPC_FSEL_A_LO], 2))
        else $error("output a frequency select wrong");
    freq_sel_b_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_FREQ_SEL) |=> ##1
        outBFreqSel_ff == $past(regWrData[`OFPC_FSEL_B_HI:`OFPC_FSEL_B_LO], 2))
        else $error("output b frequency select wrong");
    loopback_enable_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_FB_CTRL) |=> ##1
        loopbackClockOutEn_ff == $past(regWrData[`OFPC_FB_EN_BIT], 2))
        else $error("loopback clock enable wrong");
    pin_role_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_FB_CTRL) |=> ##1
        sharedPinRole_ff == $past(regWrData[`OFPC_PIN_ROLE_BIT], 2))
        else $error("shared pin role wrong");
    trim_signed_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_TRIM) |=> ##1
        finePhaseTrim_ff == $signed($past(regWrData, 2)))
        else $error("fine phase trim wrong");
    page_decode_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE && regWrData == `OFPC_PAGE_REF9) |=> ##1
        pageSel_ff == ofpc_pkg::OFPC_PG_REF9)
        else $error("page 08 not decoded");
    read_once_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regRdStb && regAddr == `OFPC_OFS_PAGE) |=> regRdData_ff == extPage_ff)
        else $error("page readback wrong");

    // output b enable follows its bit two edges after the write
    outb_enable_follows_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        outBEnable_ff == $past(regWrData[`OFPC_EN_B_BIT], 2))
        else $error("output b enable did not follow write");

    // enables only move after a write to output control
    enables_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        ($stable(outAEnable_ff) && $stable(outBEnable_ff)))
        else $error("output enables moved without a write");

    // output a alignment only moves after a write to output control
    align_a_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        $stable(outAAlignment_ff))
        else $error("output a alignment moved without a write");

    // output b alignment only moves after a write to output control
    align_b_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_OUT_CTRL) |=> ##1
        $stable(outBAlignment_ff))
        else $error("output b alignment moved without a write");

    // output a frequency code only moves after a write to frequency select
    freq_a_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_FREQ_SEL) |=> ##1
        $stable(outAFreqSel_ff))
        else $error("output a frequency moved without a write");

    // output b frequency code only moves after a write to frequency select
    freq_b_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_FREQ_SEL) |=> ##1
        $stable(outBFreqSel_ff))
        else $error("output b frequency moved without a write");

    // loopback enable only moves after a write to feedback control
    loopback_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_FB_CTRL) |=> ##1
        $stable(loopbackClockOutEn_ff))
        else $error("loopback enable moved without a write");

    // pin role only moves after a write to feedback control
    pin_role_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_FB_CTRL) |=> ##1
        $stable(sharedPinRole_ff))
        else $error("shared pin role moved without a write");

    // the one trim value only moves after a write to the trim register
    trim_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_TRIM) |=> ##1
        $stable(finePhaseTrim_ff))
        else $error("fine phase trim moved without a write");

    // page outputs only move after a write to the page register
    page_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(regWrStb && regAddr == `OFPC_OFS_PAGE) |=> ##1
        ($stable(extPage_ff) && $stable(pageSel_ff)))
        else $error("page moved without a write");

    // raw page value follows the written byte
    page_raw_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE) |=> ##1
        extPage_ff == $past(regWrData, 2))
        else $error("raw page value wrong");

    // page 00 decodes to the general registers
    page_general_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE && regWrData == `OFPC_PAGE_GENERAL) |=> ##1
        pageSel_ff == ofpc_pkg::OFPC_PG_GENERAL)
        else $error("page 00 not decoded");

    // page 01 decodes to the free-run offset registers
    page_freerun_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE && regWrData == `OFPC_PAGE_FREERUN) |=> ##1
        pageSel_ff == ofpc_pkg::OFPC_PG_FREERUN)
        else $error("page 01 not decoded");

    // page 0f decodes to the composite clock registers
    page_composite_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE && regWrData == `OFPC_PAGE_REF9_CC) |=> ##1
        pageSel_ff == ofpc_pkg::OFPC_PG_REF9_CC)
        else $error("page 0f not decoded");

    // every other page value is flagged reserved
    page_reserved_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regWrStb && regAddr == `OFPC_OFS_PAGE && regWrData != `OFPC_PAGE_GENERAL
        && regWrData != `OFPC_PAGE_FREERUN && regWrData != `OFPC_PAGE_REF9
        && regWrData != `OFPC_PAGE_REF9_CC) |=> ##1 pageSel_ff == ofpc_pkg::OFPC_PG_RESERVED)
        else $error("reserved page not flagged");

    // software reads back the same trim that the outputs use
    trim_readback_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
        (regRdStb && regAddr == `OFPC_OFS_TRIM) |=> regRdData_ff == finePhaseTrim_ff)
        else $error("trim readback differs from trim output");
endmodule // output_feedback_page_config

// *** pkg/ofpc_defs.svh ***
// Purpose: constants for the output and feedback configuration register slice
// Assumes: byte-wide registers at their printed offsets on a plain register port
// Notes:   included by the design file and the testbench
`ifndef OFPC_DEFS_SVH
`define OFPC_DEFS_SVH

// =====================================================================
// register offsets
`define OFPC_ADDR_W        7
`define OFPC_OFS_OUT_CTRL  7'h60
`define OFPC_OFS_FREQ_SEL  7'h61
`define OFPC_OFS_FB_CTRL   7'h62
`define OFPC_OFS_TRIM      7'h63
`define OFPC_OFS_PAGE      7'h64

// =====================================================================
// reset values
`define OFPC_RST_OUT_CTRL  8'ha3
`define OFPC_RST_FREQ_SEL  8'h53
`define OFPC_RST_FB_CTRL   8'h80
`define OFPC_RST_TRIM      8'he5
`define OFPC_RST_PAGE      8'h00

// =====================================================================
// field positions
`define OFPC_EN_A_BIT      0
`define OFPC_EN_B_BIT      1
`define OFPC_ALIGN_A_HI    5
`define OFPC_ALIGN_A_LO    4
`define OFPC_ALIGN_B_HI    7
`define OFPC_ALIGN_B_LO    6
`define OFPC_FSEL_A_HI     2
`define OFPC_FSEL_A_LO     0
`define OFPC_FSEL_B_HI     6
`define OFPC_FSEL_B_LO     4
`define OFPC_FB_EN_BIT     0
`define OFPC_PIN_ROLE_BIT  4

// =====================================================================
// page codes and step sizes in picoseconds
`define OFPC_PAGE_GENERAL  8'h00
`define OFPC_PAGE_FREERUN  8'h01
`define OFPC_PAGE_REF9     8'h08
`define OFPC_PAGE_REF9_CC  8'h0f
`define OFPC_ALIGN_STEP_PS 1600
`define OFPC_TRIM_STEP_PS  119.2
`define OFPC_RD_ZERO       8'h00

`endif

// *** pkg/ofpc_pkg.sv ***
// Purpose: types for the output and feedback configuration register slice
// Assumes: constants come from ofpc_defs.svh
// Notes:   nothing is imported; users write ofpc_pkg::name
package ofpc_pkg;
    // decoded extended page, one-hot
    typedef enum logic [4:0] {
        OFPC_PG_GENERAL  = 5'b00001,
        OFPC_PG_FREERUN  = 5'b00010,
        OFPC_PG_REF9     = 5'b00100,
        OFPC_PG_REF9_CC  = 5'b01000,
        OFPC_PG_RESERVED = 5'b10000
    } ofpc_page_e;
    typedef logic [7:0] ofpc_byte_t;
endpackage

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the output and feedback configuration slice
// Assumes: field outputs settle one edge after the write edge, read data one cycle later
// Notes:   table rows first, then back-to-back and reset cases by hand
`timescale 1ns/1ps
`include "ofpc_defs.svh"
module testbench;
    logic              sysClk = 1'b0;
    logic              resetN = 1'b0;
    logic [6:0]        regAddr = 7'h00;
    logic [7:0]        regWrData = 8'h00;
    logic              regWrStb = 1'b0;
    logic              regRdStb = 1'b0;
    logic [7:0]        rdData;
    logic              enA, enB, fbEn, pinRole;
    logic [1:0]        alA, alB;
    logic [2:0]        fsA, fsB;
    logic signed [7:0] trim;
    logic [7:0]        page;
    logic [4:0]        pageSel;
    int                fails = 0;
    int                cmp_count = 0;
    logic [7:0]        img [5];
    // rows: address, write data, read back; 0x65 unmapped; reserved bits at default
    logic [23:0]       rows [16] = '{24'h600000, 24'h607171, 24'h60d0d0, 24'h610707,
        24'h617070, 24'h628181, 24'h629090, 24'h638080, 24'h637f7f, 24'h640101,
        24'h640808, 24'h640f0f, 24'h640202, 24'h640e0e, 24'h655a00, 24'h640000};

    // =====================================================================
    // clock and device
    always #25 sysClk = ~sysClk;

    output_feedback_page_config uut (.sys_clk(sysClk), .reset_n(resetN), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData_ff(rdData), .outAEnable_ff(enA), .outBEnable_ff(enB),
        .outAAlignment_ff(alA), .outBAlignment_ff(alB), .outAFreqSel_ff(fsA),
        .outBFreqSel_ff(fsB), .loopbackClockOutEn_ff(fbEn), .sharedPinRole_ff(pinRole),
        .finePhaseTrim_ff(trim), .extPage_ff(page), .pageSel_ff(pageSel));

    // =====================================================================
    // helpers
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-hot page decode; anything but the four named pages is reserved
    function automatic logic [4:0] pg(input logic [7:0] p);
        case (p)
            8'h00:   return 5'h01;
            8'h01:   return 5'h02;
            8'h08:   return 5'h04;
            8'h0f:   return 5'h08;
            default: return 5'h10;
        endcase
    endfunction

    // called just after an edge; strobe drops at the sampling edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge sysClk);
        regWrStb  <= 1'b0;
        if (a >= 7'h60 && a <= 7'h64)
            img[a - 7'h60] = d;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge sysClk);
        regRdStb <= 1'b0;
        #1 chk("read data", exp, rdData);
        @(posedge sysClk);
        #1 chk("read idle", 8'h00, rdData);
    endtask

    task automatic check_all();
        chk("enable a", {7'h0, img[0][0]}, {7'h0, enA});
        chk("enable b", {7'h0, img[0][1]}, {7'h0, enB});
        chk("align a", {6'h0, img[0][5:4]}, {6'h0, alA});
        chk("align b", {6'h0, img[0][7:6]}, {6'h0, alB});
        chk("freq a", {5'h0, img[1][2:0]}, {5'h0, fsA});
        chk("freq b", {5'h0, img[1][6:4]}, {5'h0, fsB});
        chk("loopback en", {7'h0, img[2][0]}, {7'h0, fbEn});
        chk("pin role", {7'h0, img[2][4]}, {7'h0, pinRole});
        chk("trim", img[3], trim);
        chk("page", img[4], page);
        chk("page sel", {3'h0, pg(img[4])}, {3'h0, pageSel});
    endtask

    task automatic load_reset_image();
        img = '{`OFPC_RST_OUT_CTRL, `OFPC_RST_FREQ_SEL, `OFPC_RST_FB_CTRL,
                `OFPC_RST_TRIM, `OFPC_RST_PAGE};
    endtask

    // =====================================================================
    // watchdog: the whole run is about 125 cycles
    initial
    begin
        repeat (3000) @(posedge sysClk);
        fails++;
        end_of_test();
    end

    // =====================================================================
    // main sequence
    initial
    begin
        load_reset_image();
        repeat (10) @(posedge sysClk);
        resetN <= 1'b1;
        #1 check_all();
        // table rows: write, read back at once, let fields settle
        foreach (rows[i])
        begin
            wr(rows[i][22:16], rows[i][15:8]);
            rd(rows[i][22:16], rows[i][7:0]);
            repeat (2) @(posedge sysClk);
            #1 check_all();
        end
        // read then write with no gap, unmapped reads return zero
        rd(7'h63, img[3]);
        wr(7'h63, 8'h80);
        rd(7'h63, 8'h80);
        rd(7'h00, 8'h00);
        rd(7'h7f, 8'h00);
        wr(7'h61, 8'h77);
        @(posedge sysClk);
        wr(7'h60, 8'hf3);
        repeat (2) @(posedge sysClk);
        #1 check_all();
        // reset lands while a write is pending; reset image must win
        regAddr   <= 7'h62;
        regWrData <= 8'h91;
        regWrStb  <= 1'b1;
        #10 resetN <= 1'b0;
        @(posedge sysClk);
        regWrStb <= 1'b0;
        repeat (10) @(posedge sysClk);
        resetN <= 1'b1;
        load_reset_image();
        #1 check_all();
        for (int k = 0; k < 5; k++)
            rd(7'h60 + 7'(k), img[k]);
        end_of_test();
    end
endmodule // testbench
